// ==== include/smbw_bus_if.sv ====
`timescale 1ns/1ps
// open drain wires: a party pulls low when its enable is low and its output is 0
interface smbw_bus_if;
    logic host_scl_o;
    logic host_scl_oe_n;
    logic host_sda_o;
    logic host_sda_oe_n;
    logic dev_scl_o;
    logic dev_scl_oe_n;
    logic dev_sda_o;
    logic dev_sda_oe_n;
    logic scl; // resolved wire level
    logic sda; // resolved wire level

    // wired and with pull up
    assign scl = !((!host_scl_oe_n && !host_scl_o) || (!dev_scl_oe_n && !dev_scl_o));
    assign sda = !((!host_sda_oe_n && !host_sda_o) || (!dev_sda_oe_n && !dev_sda_o));

    modport host (
        output host_scl_o,
        output host_scl_oe_n,
        output host_sda_o,
        output host_sda_oe_n,
        input scl,
        input sda
    );
    modport dev (
        output dev_scl_o,
        output dev_scl_oe_n,
        output dev_sda_o,
        output dev_sda_oe_n,
        input scl,
        input sda
    );
endinterface

// ==== include/smbw_pkg.sv ====
// Operation
// R01: host opens each write with start condition
// R02: host sends address plus write; target acknowledges
// R03: index byte acknowledged, becomes first register
// R04: byte count sent next and acknowledged
// R05: host sends data bytes at consecutive indices
// R06: each data byte acknowledged and stored first
// R07: host ends write with stop condition
// R08: target address taken from latched select pin
// R09: reference clock must run for interface activity
// R10: foreign address left unacknowledged and ignored
package smbw_pkg;
    // system clock and serial clock timing
    localparam int CLK_NS = 50;
    localparam int SCL_HALF_NS = 1250;
    // least half period, rounded up to whole cycles
    localparam int SCL_HALF_CYC = (SCL_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [7:0] HALF_LAST = 8'(SCL_HALF_CYC - 1);
    // reset values
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [3:0] BIT_RST = 4'h0;
    // last bit of a byte is the acknowledge slot
    localparam logic [3:0] BIT_ACK = 4'h8;
    // phase of the transaction, by byte position
    localparam logic [1:0] PH_ADDR = 2'h0;
    localparam logic [1:0] PH_INDEX = 2'h1;
    localparam logic [1:0] PH_COUNT = 2'h2;
    localparam logic [1:0] PH_DATA = 2'h3;
    // stop sequence sub steps
    localparam logic [3:0] STP_LOW = 4'h0;
    localparam logic [3:0] STP_RISE = 4'h1;
    localparam logic [3:0] STP_FREE = 4'h2;

    typedef enum logic [2:0] {
        D_IDLE = 3'b000,
        D_RX = 3'b001,
        D_PUSH = 3'b010,
        D_ACK = 3'b011,
        D_IGNORE = 3'b100
    } smbw_dev_state_t;

    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_START = 3'b001,
        H_LOAD = 3'b010,
        H_LOW = 3'b011,
        H_HIGH = 3'b100,
        H_STOP = 3'b101
    } smbw_host_state_t;
endpackage

// ==== logic/smbw_buf2.sv ====
`timescale 1ns/1ps
// two entry buffer, valid and ready on both sides
module smbw_buf2
    import smbw_pkg::*;
#(
    parameter int W = 16
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    typedef struct packed {
        logic [1:0][W-1:0] mem; // two words
        logic wp; // write slot
        logic rp; // read slot
        logic [1:0] fill; // words held
    } smbw_buf_t;

    smbw_buf_t q;
    smbw_buf_t d;
    logic push;
    logic pop;

    // honest flags straight from the fill count
    assign in_ready = (q.fill != 2'h2);
    assign out_valid = (q.fill != 2'h0);
    assign out_data = q.mem[q.rp];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // next state
    always_comb
    begin
        d = q;
        if (push)
        begin
            d.mem[q.wp] = in_data;
            d.wp = ~q.wp;
        end
        if (pop)
            d.rp = ~q.rp;
        d.fill = 2'(q.fill + {1'b0, push} - {1'b0, pop});
    end

    // state register
    always_ff @(posedge clock)
    begin
        if (rst)
            q <= '0;
        else
            q <= d;
    end
endmodule

// ==== logic/smbw_host.sv ====
`timescale 1ns/1ps
// host end: drives a full indexed block write from a command and a byte stream
module smbw_host
    import smbw_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    smbw_bus_if.host bus,
    input wire logic ref_clk_ok,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [6:0] cmd_addr,
    input wire logic [7:0] cmd_index,
    input wire logic [7:0] cmd_count,
    input wire logic dat_valid,
    output logic dat_ready,
    input wire logic [7:0] dat_byte,
    output logic done,
    output logic nacked,
    output logic busy
);
    typedef struct packed {
        smbw_host_state_t st;
        logic [7:0] cnt; // half period timer
        logic [3:0] bitn; // bit in byte, or stop step
        logic [7:0] shift; // outgoing byte, msb first
        logic [1:0] byte_no; // header byte position
        logic [7:0] remain; // data bytes still to send
        logic [6:0] addr; // target address of this write
        logic [7:0] index; // first register index
        logic [7:0] count; // data byte count
        logic scl_low; // pull clock low
        logic sda_low; // pull data low
        logic done; // end of transaction pulse
        logic nacked; // last write was refused
    } smbw_host_t;

    localparam smbw_host_t H_RST = '{st: H_IDLE, cnt: BYTE_RST, bitn: BIT_RST,
        shift: BYTE_RST, byte_no: PH_ADDR, remain: BYTE_RST, addr: 7'h00,
        index: BYTE_RST, count: BYTE_RST, scl_low: 1'b0, sda_low: 1'b0,
        done: 1'b0, nacked: 1'b0};

    smbw_host_t q;
    smbw_host_t d;

    // header byte for a position: address with write, index, count
    function automatic logic [7:0] header_byte(
        input logic [1:0] pos,
        input logic [6:0] addr,
        input logic [7:0] index,
        input logic [7:0] count
    );
        logic [7:0] b;
        b = {addr, 1'b0};
        if (pos == PH_INDEX)
            b = index;
        else if (pos == PH_COUNT)
            b = count;
        return b;
    endfunction

    // half period done
    function automatic logic half_up(input logic [7:0] cnt);
        return cnt == HALF_LAST;
    endfunction

    // a new write only while the target can answer at all
    assign cmd_ready = (q.st == H_IDLE) && ref_clk_ok; // R09
    // a data byte is fetched only between bytes, with the clock held low
    assign dat_ready = (q.st == H_LOAD) && (q.byte_no == PH_DATA)
        && (q.remain != BYTE_RST);

    // next state
    always_comb
    begin
        d = q;
        d.done = 1'b0;
        unique case (q.st)
            H_IDLE:
            begin
                // both lines must be free before a start
                d.scl_low = 1'b0;
                d.sda_low = 1'b0;
                if (cmd_valid && cmd_ready && bus.scl && bus.sda)
                begin
                    d.addr = cmd_addr;
                    d.index = cmd_index;
                    d.count = cmd_count;
                    d.remain = cmd_count;
                    d.byte_no = PH_ADDR;
                    d.nacked = 1'b0;
                    d.cnt = BYTE_RST;
                    d.sda_low = 1'b1; // R01
                    d.st = H_START;
                end
            end
            H_START:
            begin
                // data fell with clock high; hold, then take the clock low
                d.cnt = 8'(q.cnt + 8'h01);
                if (half_up(q.cnt))
                begin
                    d.scl_low = 1'b1; // R01
                    d.cnt = BYTE_RST;
                    d.st = H_LOAD;
                end
            end
            H_LOAD:
            begin
                d.cnt = BYTE_RST;
                d.bitn = BIT_RST;
                if (q.byte_no != PH_DATA)
                begin
                    // address, then index, then count
                    d.shift = header_byte(q.byte_no, q.addr, q.index, q.count); // R02
                    d.st = H_LOW;
                end
                else if (q.remain == BYTE_RST)
                begin
                    // all bytes acknowledged: close with stop
                    d.st = H_STOP; // R07
                end
                else if (dat_valid)
                begin
                    // next byte lands on the next index at the target
                    d.shift = dat_byte; // R05
                    d.remain = 8'(q.remain - 8'h01);
                    d.st = H_LOW;
                end
            end
            H_LOW:
            begin
                // data changes only while the clock is low
                d.sda_low = (q.bitn != BIT_ACK) && !q.shift[7];
                d.cnt = 8'(q.cnt + 8'h01);
                if (half_up(q.cnt))
                begin
                    d.scl_low = 1'b0;
                    d.cnt = BYTE_RST;
                    d.st = H_HIGH;
                end
            end
            H_HIGH:
            begin
                // a target that stretches the clock stalls the timer
                if (bus.scl)
                    d.cnt = 8'(q.cnt + 8'h01);
                if (bus.scl && half_up(q.cnt))
                begin
                    d.cnt = BYTE_RST;
                    d.scl_low = 1'b1;
                    if (q.bitn != BIT_ACK)
                    begin
                        d.bitn = 4'(q.bitn + 4'h1);
                        d.shift = {q.shift[6:0], 1'b0};
                        d.st = H_LOW;
                    end
                    else if (bus.sda)
                    begin
                        // refused byte ends the write early
                        d.nacked = 1'b1;
                        d.bitn = STP_LOW;
                        d.st = H_STOP; // R07
                    end
                    else
                    begin
                        // header bytes in fixed order, then data
                        if (q.byte_no != PH_DATA)
                            d.byte_no = 2'(q.byte_no + 2'h1); // R03
                        d.st = H_LOAD; // R04
                    end
                end
            end
            H_STOP:
            begin
                d.cnt = 8'(q.cnt + 8'h01);
                unique case (q.bitn)
                    STP_LOW:
                    begin
                        // data low under a low clock
                        d.sda_low = 1'b1;
                        if (half_up(q.cnt))
                        begin
                            d.scl_low = 1'b0;
                            d.cnt = BYTE_RST;
                            d.bitn = STP_RISE;
                        end
                    end
                    STP_RISE:
                    begin
                        // wait for the clock really high, then let data rise
                        if (!bus.scl)
                            d.cnt = BYTE_RST;
                        else if (half_up(q.cnt))
                        begin
                            d.sda_low = 1'b0; // R07
                            d.cnt = BYTE_RST;
                            d.bitn = STP_FREE;
                        end
                    end
                    STP_FREE:
                    begin
                        // bus free time before the next start
                        if (half_up(q.cnt))
                        begin
                            d.cnt = BYTE_RST;
                            d.bitn = BIT_RST;
                            d.byte_no = PH_ADDR;
                            d.done = 1'b1;
                            d.st = H_IDLE;
                        end
                    end
                    default:
                        d.bitn = STP_LOW;
                endcase
            end
            default:
                d.st = H_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge clock)
    begin
        if (rst)
            q <= H_RST;
        else
            q <= d;
    end

    assign done = q.done;
    assign nacked = q.nacked;
    assign busy = (q.st != H_IDLE);
    // open drain: output always 0, enable low pulls
    assign bus.host_scl_o = 1'b0;
    assign bus.host_sda_o = 1'b0;
    assign bus.host_scl_oe_n = ~q.scl_low;
    assign bus.host_sda_oe_n = ~q.sda_low;
endmodule

// ==== logic/smbw_target.sv ====
`timescale 1ns/1ps
// target end: takes an indexed block write and streams index and data out
module smbw_target
    import smbw_pkg::*;
#(
    parameter logic [6:0] ADDR_BASE = 7'h50 // base of the address choice
)
(
    input wire logic clock,
    input wire logic rst,
    smbw_bus_if.dev bus,
    input wire logic ref_clk_running,
    input wire logic [1:0] address_select_pin,
    output logic wr_valid,
    input wire logic wr_ready,
    output logic [7:0] wr_index,
    output logic [7:0] wr_data,
    output logic [6:0] own_addr
);
    typedef struct packed {
        smbw_dev_state_t st;
        logic [1:0] ph; // byte position
        logic [3:0] bits; // bits taken of current byte
        logic [7:0] shift; // incoming byte
        logic [7:0] index; // register index to write
        logic [7:0] remain; // data bytes still due
        logic scl_p; // last scl level
        logic sda_p; // last sda level
        logic sda_low; // pull data low
        logic scl_low; // stretch clock
        logic [6:0] addr; // latched own address
        logic addr_done; // strap caught
    } smbw_dev_t;

    localparam smbw_dev_t D_RST = '{st: D_IDLE, ph: PH_ADDR, bits: BIT_RST,
        shift: BYTE_RST, index: BYTE_RST, remain: BYTE_RST, scl_p: 1'b1,
        sda_p: 1'b1, sda_low: 1'b0, scl_low: 1'b0, addr: 7'h00, addr_done: 1'b0};

    smbw_dev_t q;
    smbw_dev_t d;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic push;
    logic push_ready;
    logic [15:0] buf_out;

    // bus events, both lines taken as synchronous
    assign scl_rise = bus.scl && !q.scl_p;
    assign scl_fall = !bus.scl && q.scl_p;
    assign start_seen = q.scl_p && bus.scl && q.sda_p && !bus.sda;
    assign stop_seen = q.scl_p && bus.scl && !q.sda_p && bus.sda;
    assign push = (q.st == D_PUSH);

    // next state
    always_comb
    begin
        d = q;
        d.scl_p = bus.scl;
        d.sda_p = bus.sda;
        // strap caught once, on the first edge after reset release
        if (!q.addr_done)
        begin
            d.addr = 7'(ADDR_BASE + {5'h00, address_select_pin}); // R08
            d.addr_done = 1'b1;
        end
        if (!ref_clk_running)
        begin
            // without the reference clock the port is dead: let go of both lines
            d.st = D_IDLE; // R09
            d.sda_low = 1'b0;
            d.scl_low = 1'b0;
        end
        else if (start_seen)
        begin
            // start or repeated start: fresh address byte
            d.st = D_RX;
            d.ph = PH_ADDR;
            d.bits = BIT_RST;
            d.sda_low = 1'b0;
            d.scl_low = 1'b0;
        end
        else if (stop_seen)
        begin
            d.st = D_IDLE;
            d.sda_low = 1'b0;
            d.scl_low = 1'b0;
        end
        else
        begin
            unique case (q.st)
                D_IDLE:
                    d.sda_low = 1'b0;
                D_RX:
                begin
                    // shift on rise, decide on the fall after the eighth bit
                    if (scl_rise)
                    begin
                        d.shift = {q.shift[6:0], bus.sda};
                        d.bits = 4'(q.bits + 4'h1);
                    end
                    else if (scl_fall && q.bits == BIT_ACK)
                    begin
                        d.st = D_ACK;
                        d.sda_low = 1'b1;
                        unique case (q.ph)
                            PH_ADDR:
                            begin
                                // write to our own address only
                                if (q.shift[7:1] != q.addr || q.shift[0])
                                begin
                                    d.st = D_IGNORE; // R10
                                    d.sda_low = 1'b0;
                                end
                            end
                            PH_INDEX:
                                d.index = q.shift; // R03
                            PH_COUNT:
                                d.remain = q.shift; // R04
                            PH_DATA:
                            begin
                                // hold clock low until the word is safely queued
                                d.sda_low = 1'b0;
                                if (q.remain != BYTE_RST)
                                begin
                                    d.st = D_PUSH; // R06
                                    d.scl_low = 1'b1;
                                end
                                else
                                    d.st = D_IGNORE;
                            end
                        endcase
                    end
                end
                D_PUSH:
                begin
                    // stretch lasts while full, and one cycle into the ack
                    if (push_ready)
                    begin
                        d.index = 8'(q.index + 8'h01); // R06
                        d.remain = 8'(q.remain - 8'h01);
                        d.sda_low = 1'b1;
                        d.st = D_ACK;
                    end
                end
                D_ACK:
                begin
                    d.scl_low = 1'b0; // ack already stands
                    // release data at the end of the ninth clock
                    if (scl_fall)
                    begin
                        d.sda_low = 1'b0; // R02
                        d.bits = BIT_RST;
                        d.st = D_RX;
                        if (q.ph != PH_DATA)
                            d.ph = 2'(q.ph + 2'h1);
                    end
                end
                D_IGNORE:
                    d.sda_low = 1'b0; // R10
                default:
                    d.st = D_IDLE;
            endcase
        end
    end

    // state register
    always_ff @(posedge clock)
    begin
        if (rst)
            q <= D_RST;
        else
            q <= d;
    end

    // a receiver stall queues in here instead of dropping a byte
    smbw_buf2 #(
        .W(16)
    ) u_buf (
        .clock(clock),
        .rst(rst),
        .in_valid(push),
        .in_ready(push_ready),
        .in_data({q.index, q.shift}),
        .out_valid(wr_valid),
        .out_ready(wr_ready),
        .out_data(buf_out)
    );

    assign wr_index = buf_out[15:8];
    assign wr_data = buf_out[7:0];
    assign own_addr = q.addr;
    // open drain: output always 0, enable low pulls
    assign bus.dev_sda_o = 1'b0;
    assign bus.dev_scl_o = 1'b0;
    assign bus.dev_sda_oe_n = ~q.sda_low;
    assign bus.dev_scl_oe_n = ~q.scl_low;
endmodule

// ==== testbench/smbus_indexed_block_write_tb_top.sv ====
`timescale 1ns/1ps
// host and target joined over one bus, user sides driven here
module smbus_indexed_block_write_tb_top;
    // one table row: strap, command, expected refusal
    typedef struct packed {
        logic [1:0] sel;
        logic [6:0] addr;
        logic [7:0] idx;
        logic [7:0] cnt;
        logic nack;
    } smbw_row_t;
    smbw_row_t rows [4] = '{
        '{2'h0, 7'h50, 8'h10, 8'h02, 1'b0},
        '{2'h3, 7'h53, 8'hf0, 8'h04, 1'b0},
        '{2'h1, 7'h50, 8'h20, 8'h01, 1'b1}, // foreign address
        '{2'h2, 7'h52, 8'h7f, 8'h00, 1'b0} // empty block
    };
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic ref_clk_ok = 1'b1;
    logic ref_clk_running = 1'b1;
    logic cmd_valid = 1'b0;
    logic [6:0] cmd_addr = 7'h00;
    logic [7:0] cmd_index = 8'h00;
    logic [7:0] cmd_count = 8'h00;
    logic dat_valid = 1'b0;
    logic [7:0] dat_byte = 8'h00;
    logic [1:0] address_select_pin = 2'h0;
    logic wr_ready = 1'b1;
    logic cmd_ready, dat_ready, done, nacked, busy, wr_valid;
    logic [7:0] wr_index, wr_data;
    logic [6:0] own_addr;
    int n_errors = 0;
    int comparisons = 0;
    int cyc = 0; // timeout count
    logic [15:0] got [$]; // index and data popped from target
    logic dtake = 1'b0; // byte taken at the coming edge
    logic [7:0] n_sent = 8'h00;
    logic [7:0] n_total = 8'h00;
    logic [7:0] dbase = 8'h00;
    logic seen_nack;

    smbw_bus_if bus ();
    smbw_host smbw_host_inst (.clock(clock), .rst(rst), .bus(bus), .ref_clk_ok(ref_clk_ok),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_addr(cmd_addr),
        .cmd_index(cmd_index), .cmd_count(cmd_count), .dat_valid(dat_valid),
        .dat_ready(dat_ready), .dat_byte(dat_byte), .done(done), .nacked(nacked), .busy(busy));
    smbw_target #(.ADDR_BASE(7'h50)) smbw_target_inst (.clock(clock), .rst(rst), .bus(bus),
        .ref_clk_running(ref_clk_running), .address_select_pin(address_select_pin),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_index(wr_index), .wr_data(wr_data),
        .own_addr(own_addr));
    smbw_checker smbw_checker_inst (.clock(clock), .rst(rst),
        .host_sda_oe_n(bus.host_sda_oe_n), .dev_scl_oe_n(bus.dev_scl_oe_n),
        .dev_sda_oe_n(bus.dev_sda_oe_n), .scl(bus.scl), .sda(bus.sda));

    always #25 clock = ~clock;

    // handshakes judged mid cycle, once everything has settled
    always @(negedge clock)
    begin
        dtake = dat_valid && dat_ready;
        if (wr_valid === 1'b1 && wr_ready === 1'b1)
            got.push_back({wr_index, wr_data});
    end

    // byte stream moves on after each taken byte; hang guard
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            n_errors++;
            complete_run();
        end
        if (dtake)
        begin
            n_sent <= n_sent + 8'h01;
            dat_byte <= dbase + n_sent + 8'h01;
            dat_valid <= (n_sent + 8'h01 < n_total);
        end
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
        comparisons++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // strap is caught on the first edge after release
    task automatic restart(input logic [1:0] sel);
        @(posedge clock);
        rst <= 1'b1;
        address_select_pin <= sel;
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        repeat (2) @(posedge clock);
    endtask

    // one whole write: command held until taken, then wait for done
    task automatic send(input logic [6:0] a, input logic [7:0] n, input logic [7:0] x,
        input logic [7:0] base);
        int i;
        got.delete();
        @(posedge clock);
        cmd_valid <= 1'b1;
        cmd_addr <= a;
        cmd_index <= n;
        cmd_count <= x;
        n_total <= x;
        n_sent <= 8'h00;
        dbase <= base;
        dat_byte <= base;
        dat_valid <= (x != 8'h00);
        for (i = 0; i < 100; i++)
        begin
            @(negedge clock);
            if (cmd_ready === 1'b1 && bus.scl === 1'b1 && bus.sda === 1'b1)
                break;
        end
        @(posedge clock);
        cmd_valid <= 1'b0;
        for (i = 0; i < 8000; i++)
        begin
            @(negedge clock);
            if (done === 1'b1)
                break;
        end
        seen_nack = nacked;
        chk("done", 16'h0001, {15'h0000, done});
    endtask

    // words must arrive at consecutive indices, in order
    task automatic expect_words(input logic [7:0] n, input logic [7:0] x, input logic [7:0] base);
        repeat (4) @(posedge clock);
        chk("word count", {8'h00, x}, 16'(got.size()));
        for (int k = 0; k < got.size() && k < x; k++)
            chk("word", {n + 8'(k), base + 8'(k)}, got[k]);
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (3) @(posedge clock);
        @(negedge clock);
        // lines released, cmd_ready high and other outputs quiet in reset
        chk("reset outputs", 16'h0086,
            {8'h00, cmd_ready, busy, done, nacked, wr_valid, bus.scl, bus.sda, dat_ready});
        @(posedge clock);
        rst <= 1'b0;
        $display("test reset done");
        foreach (rows[r])
        begin
            restart(rows[r].sel);
            chk("own address", {9'h000, 7'h50 + 7'(rows[r].sel)}, {9'h000, own_addr});
            send(rows[r].addr, rows[r].idx, rows[r].cnt, 8'ha0 + 8'(r));
            chk("nacked", {15'h0000, rows[r].nack}, {15'h0000, seen_nack});
            expect_words(rows[r].idx, rows[r].nack ? 8'h00 : rows[r].cnt, 8'ha0 + 8'(r));
            $display("test row %0d done", r);
        end
        // reader stalls: buffer fills, target stretches, nothing lost
        wr_ready <= 1'b0;
        fork
            begin
                repeat (3000) @(posedge clock);
                wr_ready <= 1'b1;
            end
        join_none
        send(7'h52, 8'h40, 8'h04, 8'hc0);
        chk("stall nacked", 16'h0000, {15'h0000, seen_nack});
        expect_words(8'h40, 8'h04, 8'hc0);
        $display("test stall done");
        // no reference clock at the host: command refused
        @(posedge clock);
        ref_clk_ok <= 1'b0;
        cmd_valid <= 1'b1;
        repeat (3) @(negedge clock);
        chk("refused", 16'h0000, {14'h0000, cmd_ready, busy});
        @(posedge clock);
        cmd_valid <= 1'b0;
        ref_clk_ok <= 1'b1;
        ref_clk_running <= 1'b0;
        // no reference clock at the target: silent
        send(7'h52, 8'h00, 8'h01, 8'h11);
        chk("no clock nacked", 16'h0001, {15'h0000, seen_nack});
        expect_words(8'h00, 8'h00, 8'h11);
        $display("test reference clock done");
        complete_run();
    end
endmodule

// ==== testbench/smbw_checker.sv ====
`timescale 1ns/1ps
// watches the shared wires between host and target
module smbw_checker (
    input wire logic clock,
    input wire logic rst,
    input wire logic host_sda_oe_n,
    input wire logic dev_scl_oe_n,
    input wire logic dev_sda_oe_n,
    input wire logic scl,
    input wire logic sda
);
    logic [3:0] bit_cnt; // scl rises seen in the current byte
    logic scl_q; // scl one cycle ago
    logic sda_q; // sda one cycle ago

    // count bit clocks; a start restarts the byte
    always_ff @(posedge clock)
    begin
        scl_q <= scl;
        sda_q <= sda;
        if (rst || (scl && sda_q && !sda))
            bit_cnt <= 4'h0;
        else if (scl && !scl_q)
            bit_cnt <= (bit_cnt == 4'h9) ? 4'h1 : bit_cnt + 4'h1;
    end

    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    // a start is followed by the first clock low
    a_start_then_clock: assert property ($fell(sda) && scl |-> ##[1:30] !scl)
        else $error("start not followed by clock low");
    // after a stop the bus stays idle a while
    a_stop_idle: assert property ($rose(sda) && scl |-> (scl && sda)[*8])
        else $error("bus not idle after stop");
    // ack pulled only in the ninth bit slot
    a_ack_slot: assert property ($fell(dev_sda_oe_n) |-> bit_cnt == 4'h8)
        else $error("ack pulled outside its slot");
    // ack released at the ninth falling edge
    a_ack_release: assert property ($rose(dev_sda_oe_n) |-> bit_cnt == 4'h9)
        else $error("ack released at wrong bit");
    // ack held across the high phase, bounded even with stretching
    a_ack_hold: assert property ($fell(dev_sda_oe_n) |-> ##[40:1000] dev_sda_oe_n)
        else $error("ack length out of range");
    // target data line moves only while clock is low
    a_sda_change_low: assert property ($changed(dev_sda_oe_n) |-> !scl)
        else $error("target data moved with clock high");
    // host lets go of data for the ack bit
    a_host_frees: assert property ($rose(scl) && bit_cnt == 4'h8 |-> host_sda_oe_n)
        else $error("host drives data in ack slot");
    // stretching begins only on a held-low clock after a byte
    a_stretch_slot: assert property ($fell(dev_scl_oe_n) |-> bit_cnt == 4'h8 && !$past(scl))
        else $error("stretch outside byte end");
    // clock high phase is never a glitch
    a_scl_high: assert property ($rose(scl) |-> scl[*8])
        else $error("clock high phase too short");
endmodule
